// ### src/adc_seq_pkg.sv
// Package: constants and carrier types for the converter channel sequencer
package adc_seq_pkg;

  localparam int          CHAN_W          = 2;
  localparam int          RESULT_W        = 12;
  localparam int          CTRL_W          = 12;
  // Control word field positions
  localparam int          POS_ADDR_LO     = 0;
  localparam int          POS_ADDR_HI     = 1;
  localparam int          POS_SEQ_A       = 2;
  localparam int          POS_SEQ_B       = 3;
  localparam int          POS_CFG_A       = 4;
  localparam int          POS_CFG_B       = 5;
  localparam int          POS_REF_SEL     = 6;
  localparam logic [11:0] CTRL_RESET      = 12'h000;
  localparam logic [1:0]  CHAN_ZERO       = 2'h0;
  localparam logic [1:0]  HIGH_PAD        = 2'h0;
  // Synchroniser depth of the host-facing pins, in flip-flop stages
  localparam int          SYNC_STAGES     = 2;

  typedef enum logic [2:0] {
    CFG_SINGLE = 3'b001,
    CFG_DIFF   = 3'b010,
    CFG_PSEUDO = 3'b100
  } input_cfg_t;

  typedef struct packed {
    logic [1:0] addr;
    logic       seqA;
    logic       seqB;
    logic       cfgA;
    logic       cfgB;
    logic       refSel;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] muxChannel;
    logic       pairMode;
    logic       pseudoMode;
    logic       negToGround;
    logic       refInternal;
    logic       refDriveEn;
  } analog_sel_t;

endpackage : adc_seq_pkg

// ### src/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] resetValue,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= asyncIn ^ resetValue;
      stage2Reg <= stage1Reg;
    end
  end

  // Idle-high pins are stored inverted so the async reset stays a constant zero
  assign syncOut = stage2Reg ^ resetValue;
endmodule // pin_sync
`default_nettype wire

// ### src/adc_channel_sequencer.sv
// Channel sequencer, input configuration and reference control of the converter
`timescale 1ns/100ps
`default_nettype none
module adc_channel_sequencer
  import adc_seq_pkg::*;
#(
  parameter int NUM_CHANNELS = 4
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [CTRL_W-1:0]   ctrlWord,
  input  wire logic                writeStrobe_n,
  input  wire logic                conversion_start_n,
  input  wire logic [RESULT_W-1:0] convResult,
  input  wire logic                resultValid,
  input  wire logic                high_byte_select,
  output logic      [7:0]          byteOut,
  output var analog_sel_t          analogSel,
  output logic      [CHAN_W-1:0]   convChannel,
  output logic                     convStart
);

  typedef struct packed {
    ctrl_t              ctrl;
    logic [CHAN_W-1:0]  pointer;
    logic [CHAN_W-1:0]  convChan;
    logic [CHAN_W-1:0]  resultChan;
    logic               startPulse;
    logic               wrPrev;
    logic               cvPrev;
    logic [7:0]         byteData;
    analog_sel_t        sel;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [CTRL_W-1:0] ctrlSync;
  logic              wrSync;
  logic              cvSync;
  logic              hbSync;
  input_cfg_t        cfgMode;
  ctrl_t             ctrlNew;
  logic              wrRise;
  logic              cvFall;
  logic              seqMode;

  pin_sync #(
    .WIDTH (CTRL_W + 3)
  ) u_pin_sync (
    .clk        (clk),
    .reset_n    (reset_n),
    .asyncIn    ({ctrlWord, writeStrobe_n, conversion_start_n, high_byte_select}),
    .resetValue ({CTRL_RESET, 1'b1, 1'b1, 1'b0}),
    .syncOut    ({ctrlSync, wrSync, cvSync, hbSync})
  );

  always_comb begin
    ctrlNew        = '0;
    ctrlNew.addr   = {ctrlSync[POS_ADDR_HI], ctrlSync[POS_ADDR_LO]};
    ctrlNew.seqA   = ctrlSync[POS_SEQ_A];
    ctrlNew.seqB   = ctrlSync[POS_SEQ_B];
    ctrlNew.cfgA   = ctrlSync[POS_CFG_A];
    ctrlNew.cfgB   = ctrlSync[POS_CFG_B];
    ctrlNew.refSel = ctrlSync[POS_REF_SEL];
  end

  always_comb begin
    state_next = state_reg;
    state_next.wrPrev = wrSync;
    state_next.cvPrev = cvSync;
    state_next.startPulse = 1'b0;
    // Write latched on the strobe's rising edge
    wrRise = wrSync && !state_reg.wrPrev;
    cvFall = !cvSync && state_reg.cvPrev;
    seqMode = state_reg.ctrl.seqA && state_reg.ctrl.seqB;

    if (wrRise) begin
      state_next.ctrl = ctrlNew;
      state_next.pointer = CHAN_ZERO;
    end

    if (cvFall) begin
      state_next.startPulse = 1'b1;
      if (seqMode) begin
        state_next.convChan = state_reg.pointer;
        if (state_reg.pointer >= state_reg.ctrl.addr) begin
          state_next.pointer = CHAN_ZERO;
        end else begin
          state_next.pointer = state_reg.pointer + 2'h1;
        end
      end else begin
        state_next.convChan = state_reg.ctrl.addr;
      end
      if (wrRise) begin
        state_next.pointer = CHAN_ZERO;
      end
    end

    if (state_reg.ctrl.cfgA && !state_reg.ctrl.cfgB) begin
      cfgMode = CFG_PSEUDO;
    end else if (!state_reg.ctrl.cfgA && state_reg.ctrl.cfgB) begin
      cfgMode = CFG_DIFF;
    end else begin
      cfgMode = CFG_SINGLE;
    end

    state_next.sel.muxChannel = state_next.convChan;
    unique case (cfgMode)
      CFG_SINGLE: begin
        state_next.sel.pairMode    = 1'b0;
        state_next.sel.pseudoMode  = 1'b0;
        state_next.sel.negToGround = 1'b1;
      end
      CFG_DIFF: begin
        state_next.sel.pairMode    = 1'b1;
        state_next.sel.pseudoMode  = 1'b0;
        state_next.sel.negToGround = 1'b0;
      end
      CFG_PSEUDO: begin
        state_next.sel.pairMode    = 1'b1;
        state_next.sel.pseudoMode  = 1'b1;
        state_next.sel.negToGround = 1'b0;
      end
    endcase
    state_next.sel.refInternal = state_reg.ctrl.refSel;
    state_next.sel.refDriveEn  = state_reg.ctrl.refSel;

    if (resultValid) begin
      state_next.resultChan = state_reg.convChan;
    end
    if (hbSync) begin
      state_next.byteData = {HIGH_PAD, state_reg.resultChan, convResult[11:8]};
    end else begin
      state_next.byteData = convResult[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{ctrl: '0, pointer: '0, convChan: '0, resultChan: '0,
                     startPulse: 1'b0, wrPrev: 1'b1, cvPrev: 1'b1, byteData: 8'h00,
                     sel: '{muxChannel: '0, pairMode: 1'b0, pseudoMode: 1'b0,
                            negToGround: 1'b1, refInternal: 1'b0, refDriveEn: 1'b0}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign byteOut     = state_reg.byteData;
  assign analogSel   = state_reg.sel;
  assign convChannel = state_reg.convChan;
  assign convStart   = state_reg.startPulse;

endmodule // adc_channel_sequencer
`default_nettype wire

// ### dv/adc_seq_monitor.sv
// Checker of start, channel, configuration and read-byte relations
`timescale 1ns/100ps
`default_nettype none
module adc_seq_monitor
  import adc_seq_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        conversion_start_n,
  input wire logic [11:0] convResult,
  input wire logic        high_byte_select,
  input wire logic [7:0]  byteOut,
  input wire analog_sel_t analogSel,
  input wire logic [1:0]  convChannel,
  input wire logic        convStart
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  start_latency_a: assert property ($fell(conversion_start_n) |-> ##[3:4] convStart)
    else $error("start pulse missing");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  mux_track_a: assert property (convStart |-> analogSel.muxChannel == convChannel)
    else $error("mux differs from channel");
  neg_ground_a: assert property (analogSel.negToGround == !analogSel.pairMode)
    else $error("ground tie wrong");
  pseudo_pair_a: assert property (analogSel.pseudoMode |-> analogSel.pairMode)
    else $error("pseudo without pair");
  ref_drive_a: assert property (analogSel.refDriveEn == analogSel.refInternal)
    else $error("reference drive wrong");
  high_byte_a: assert property (high_byte_select [*4] |=>
    byteOut[7:6] == HIGH_PAD && byteOut[3:0] == $past(convResult[11:8])) else $error("high byte wrong");
  low_byte_a: assert property ((!high_byte_select) [*4] |=> byteOut == $past(convResult[7:0]))
    else $error("low byte wrong");
  cover property (convStart && convChannel == 2'h3);
  cover property (analogSel.pseudoMode);
  cover property (high_byte_select [*4]);
endmodule // adc_seq_monitor
`default_nettype wire

// ### dv/host_model.sv
// Host processor model driving control word, write strobe and conversion start
`timescale 1ns/100ps
`default_nettype none
module host_model
  import adc_seq_pkg::*;
(
  input  wire logic              clk,
  output logic      [CTRL_W-1:0] ctrlWord = '0,
  output logic                   writeStrobe_n = 1'b1,
  output logic                   conversion_start_n = 1'b1
);
  task automatic writeCtrl(input logic [CTRL_W-1:0] w);
    ctrlWord <= w;
    writeStrobe_n <= 1'b0;
    repeat (2) @(posedge clk);
    writeStrobe_n <= 1'b1; // Held high until next word
    repeat (5) @(posedge clk);
    ctrlWord <= ~w;
  endtask
  task automatic startConv();
    conversion_start_n <= 1'b0;
    repeat (2) @(posedge clk);
    conversion_start_n <= 1'b1;
  endtask
endmodule // host_model
`default_nettype wire

// ### dv/adc_channel_sequencer_test.sv
// Bench: host model, reference model and checks for the channel sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_channel_sequencer_test;
  import adc_seq_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              resultValid = 1'b0;
  logic              high_byte_select = 1'b0;
  logic              writeStrobe_n, conversion_start_n, convStart;
  logic [CTRL_W-1:0] ctrlWord, w;
  logic [11:0]       convResult = 12'h000, r;
  logic [7:0]        byteOut;
  logic [1:0]        convChannel;
  analog_sel_t       analogSel;
  int                fail_count = 0, check_count = 0, seed = 32, ptr, ch, n;
  logic [11:0]       words [4] = '{12'h04F, 12'h01D, 12'h022, 12'h070};
  initial forever #10 clk = ~clk;
  host_model host_model_i (.clk, .ctrlWord, .writeStrobe_n, .conversion_start_n);
  adc_channel_sequencer adc_channel_sequencer_i (.clk, .reset_n, .ctrlWord, .writeStrobe_n, .conversion_start_n,
    .convResult, .resultValid, .high_byte_select, .byteOut, .analogSel, .convChannel, .convStart);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic convert();
    host_model_i.startConv();
    n = 0;
    while (convStart !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    if (n == 8) begin
      fail_count++;
      test_done();
    end
    ch = (w[3:2] == 2'b11) ? ptr : int'(w[1:0]);
    if (w[3:2] == 2'b11) ptr = (ptr == int'(w[1:0])) ? 0 : ptr + 1;
    check("channel", 16'(convChannel), 16'(ch));
    check("select", 16'(analogSel), 16'({2'(ch), w[5] ^ w[4], w[4] & ~w[5], ~(w[5] ^ w[4]), w[6], w[6]}));
    r = 12'($random(seed));
    convResult <= r;
    resultValid <= 1'b1;
    high_byte_select <= 1'b1;
    @(posedge clk);
    resultValid <= 1'b0;
    repeat (4) @(posedge clk);
    check("high byte", 16'(byteOut), 16'({2'b00, 2'(ch), r[11:8]}));
    high_byte_select <= 1'b0;
    repeat (4) @(posedge clk);
    check("low byte", 16'(byteOut), 16'(r[7:0]));
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      w = (i < 4) ? words[i] : 12'($random(seed)) & 12'h07F;
      host_model_i.writeCtrl(w);
      ptr = 0;
      repeat (6) convert();
      $display("word %h done", w);
    end
    test_done();
  end
endmodule // adc_channel_sequencer_test
bind adc_channel_sequencer adc_seq_monitor adc_seq_monitor_i (.clk, .reset_n, .conversion_start_n, .convResult,
  .high_byte_select, .byteOut, .analogSel, .convChannel, .convStart);
`default_nettype wire
